// *** design/rwa_pkg.sv ***
// package for the receive word aligner: register map, field positions, reset values, timing
// assumes one 100 MHz parallel clock shared by the apb side and the deserialized data path
package rwa_pkg;
    // register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_PATTERN = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_CHRST = 8'h0c;
    localparam logic [7:0] REG_BOUND = 8'h10;
    // control fields
    localparam int CTRL_MANUAL = 0;
    localparam int CTRL_SLIP_EN = 1;
    localparam int CTRL_WSEL_LO = 2;
    localparam int CTRL_ALIGN_EN = 4;
    localparam logic [31:0] CTRL_RESET = 32'h0000_000c;
    localparam logic [31:0] PATTERN_RESET = 32'h0000_0000;
    // status fields, one bit per channel from each base
    localparam int STAT_SYNC_LO = 0;
    localparam int STAT_PDET_LO = 8;
    localparam int STAT_OVF_LO = 16;
    localparam int BOUND_BITS = 5;
    localparam int MAXW = 20;
    localparam logic [4:0] BOUND_RESET = 5'h00;
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int SLIP_HOLD_NS = 200;
    // sample the slip request twice per minimum hold time (longest spacing, rounds down)
    localparam int SLOW_CYC = SLIP_HOLD_NS / 2 / CLK_PERIOD_NS;
    localparam int SYNC_DELAY = 3;

    typedef enum logic [1:0] {RWA_IDLE = 2'b00, RWA_SEARCH = 2'b01, RWA_LOCKED = 2'b11} rwa_state_t;
    typedef enum logic [1:0] {RWA_W8 = 2'b00, RWA_W10 = 2'b01, RWA_W16 = 2'b10, RWA_W20 = 2'b11} rwa_width_t;

    // word width in bits for a width select
    function automatic logic [4:0] rwa_wbits(input rwa_width_t s);
        unique case (s)
            RWA_W8: rwa_wbits = 5'h08;
            RWA_W10: rwa_wbits = 5'h0a;
            RWA_W16: rwa_wbits = 5'h10;
            RWA_W20: rwa_wbits = 5'h14;
        endcase
    endfunction

    // low-bit mask for a width select
    function automatic logic [19:0] rwa_mask(input rwa_width_t s);
        unique case (s)
            RWA_W8: rwa_mask = 20'h000ff;
            RWA_W10: rwa_mask = 20'h003ff;
            RWA_W16: rwa_mask = 20'h0ffff;
            RWA_W20: rwa_mask = 20'hfffff;
        endcase
    endfunction
endpackage

// *** design/rwa_sync.sv ***
// two-flop level synchronizer for pins from outside the clock domain
// assumes the inputs are levels held far longer than one clock
`timescale 1ns/1ps
module rwa_sync #(
    parameter int W = 1
) (
    input wire logic clk, // sampling clock
    input wire logic rst_n, // async reset, active low
    input wire logic [W-1:0] d, // asynchronous levels
    output logic [W-1:0] q // synchronized levels
);
    import rwa_pkg::*;
    logic [W-1:0] meta;
    // first stage feeds only the second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule // rwa_sync

// *** design/rwa_fifo.sv ***
// small fifo with a registered output stage between aligner and fabric
// assumes DEPTH is a power of two; holds DEPTH words plus one in the output register
`timescale 1ns/1ps
module rwa_fifo #(
    parameter int W = 20,
    parameter int DEPTH = 8
) (
    input wire logic clk, // clock
    input wire logic rst_n, // async reset, active low
    input wire logic in_valid, // write request
    output logic in_ready, // room for a word
    input wire logic [W-1:0] in_data, // write data
    output logic out_valid, // head word present
    input wire logic out_ready, // consumer takes head
    output logic [W-1:0] out_data // head word, registered
);
    import rwa_pkg::*;
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW:0] cnt, next_cnt;
    logic [AW-1:0] wp, rp, next_wp, next_rp;
    logic next_out_valid;
    logic [W-1:0] next_out_data;
    logic wr, ld;

    // honest full: ready drops once DEPTH words wait
    assign in_ready = cnt != (AW + 1)'(DEPTH);
    assign wr = in_valid & in_ready;
    assign ld = (cnt != '0) & (!out_valid | out_ready);

    // pointer and output-stage next values
    always_comb begin
        next_wp = wr ? wp + 1'b1 : wp;
        next_rp = ld ? rp + 1'b1 : rp;
        next_cnt = cnt + (AW + 1)'(wr) - (AW + 1)'(ld);
        next_out_valid = ld | (out_valid & !out_ready);
        next_out_data = ld ? mem[rp] : out_data;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp <= '0;
            rp <= '0;
            cnt <= '0;
            out_valid <= 1'b0;
            out_data <= '0;
        end else begin
            wp <= next_wp;
            rp <= next_rp;
            cnt <= next_cnt;
            out_valid <= next_out_valid;
            out_data <= next_out_data;
        end
    end

    // storage needs no reset, count guards reads
    always_ff @(posedge clk) begin
        if (wr) begin
            mem[wp] <= in_data;
        end
    end
endmodule // rwa_fifo

// *** design/rwa_aligner.sv ***
// receive word aligner: bit slip and manual pattern alignment, apb registers, per-channel fifo
// assumes pma_data arrives on pclk one word per cycle; slip and align pins are asynchronous
`timescale 1ns/1ps
module rwa_aligner #(
    parameter int NCH = 1, // channels, at most 6 for the boundary register
    parameter int FIFO_DEPTH = 8, // words per channel fifo
    parameter bit SLIP_PORT_EN = 1'b1, // slip request port configured in
    parameter bit ALIGN_PORT_EN = 1'b1 // align request port configured in
) (
    input wire logic pclk, // parallel clock
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb write
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    input wire logic [NCH*rwa_pkg::MAXW-1:0] pma_data, // deserialized words, lsb first
    output logic [NCH-1:0] pma_ready, // fifo has room for the next word
    input wire logic [NCH-1:0] slip_request, // bit slip pins
    input wire logic [NCH-1:0] align_request, // realignment pins
    output logic [NCH*rwa_pkg::MAXW-1:0] rx_data, // aligned words
    output logic [NCH-1:0] rx_valid, // aligned word present
    input wire logic [NCH-1:0] rx_ready, // fabric takes word
    output logic [NCH-1:0] pattern_detect, // pattern matched
    output logic [NCH-1:0] sync_status // synchronized or realign pulse
);
    import rwa_pkg::*;

    logic [31:0] ctrl, next_ctrl, pattern, next_pattern, prdata_n;
    logic [NCH-1:0] chan_rst, next_chan_rst, ovf, next_ovf;
    logic [NCH-1:0] slip_s, align_s, fifo_in_ready;
    logic [NCH*BOUND_BITS-1:0] bound_all;
    logic [7:0] slow_cnt, next_slow_cnt;
    logic slow_en, wr_en, rd_setup, addr_ok;
    logic manual, slip_mode_ok;
    rwa_width_t wsel;
    logic [4:0] w;
    logic [19:0] mask, pat_m;

    assign manual = ctrl[CTRL_MANUAL];
    assign slip_mode_ok = SLIP_PORT_EN & ctrl[CTRL_SLIP_EN] & !manual;
    assign wsel = rwa_width_t'(ctrl[CTRL_WSEL_LO+1:CTRL_WSEL_LO]);
    assign w = rwa_wbits(wsel);
    assign mask = rwa_mask(wsel);
    assign pat_m = pattern[19:0] & mask;

    // pins from fabric cross in through two flops
    rwa_sync #(.W(2 * NCH)) u_pin_sync (
        .clk(pclk),
        .rst_n(presetn),
        .d({align_request, slip_request}),
        .q({align_s, slip_s})
    );

    // slow sampling enable for slip requests; a short glitch still gives a slip if it covers a sample
    always_comb begin
        next_slow_cnt = (slow_cnt == 8'(SLOW_CYC - 1)) ? 8'h00 : slow_cnt + 8'h01;
    end
    assign slow_en = slow_cnt == 8'(SLOW_CYC - 1);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slow_cnt <= 8'h00;
        end else begin
            slow_cnt <= next_slow_cnt;
        end
    end

    // apb decode: zero wait states, read data captured in the setup cycle
    assign pready = 1'b1;
    assign wr_en = psel & penable & pwrite & addr_ok;
    assign rd_setup = psel & !penable & !pwrite;
    assign addr_ok = paddr == REG_CTRL || paddr == REG_PATTERN || paddr == REG_STATUS ||
                     paddr == REG_CHRST || paddr == REG_BOUND;
    assign pslverr = psel & penable & !addr_ok;

    always_comb begin
        next_ctrl = ctrl;
        next_pattern = pattern;
        next_chan_rst = chan_rst;
        prdata_n = prdata;
        // overflow is sticky; a new overflow beats a write-one clear
        next_ovf = ovf & ~((wr_en && paddr == REG_STATUS) ? pwdata[STAT_OVF_LO+:NCH] : '0);
        next_ovf = next_ovf | ~fifo_in_ready;
        if (wr_en) begin
            if (paddr == REG_CTRL) next_ctrl = pwdata & 32'h0000_001f;
            if (paddr == REG_PATTERN) next_pattern = pwdata & 32'h000f_ffff;
            if (paddr == REG_CHRST) next_chan_rst = pwdata[NCH-1:0];
        end
        if (rd_setup) begin
            prdata_n = 32'h0000_0000;
            unique case (paddr)
                REG_CTRL: prdata_n = ctrl;
                REG_PATTERN: prdata_n = pattern;
                REG_STATUS: begin
                    prdata_n[STAT_SYNC_LO+:NCH] = sync_status;
                    prdata_n[STAT_PDET_LO+:NCH] = pattern_detect;
                    prdata_n[STAT_OVF_LO+:NCH] = ovf;
                end
                REG_CHRST: prdata_n[NCH-1:0] = chan_rst;
                REG_BOUND: prdata_n[NCH*BOUND_BITS-1:0] = bound_all;
                default: prdata_n = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= CTRL_RESET;
            pattern <= PATTERN_RESET;
            chan_rst <= '0;
            ovf <= '0;
            prdata <= 32'h0000_0000;
        end else begin
            ctrl <= next_ctrl;
            pattern <= next_pattern;
            chan_rst <= next_chan_rst;
            ovf <= next_ovf;
            prdata <= prdata_n;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // one independent aligner per channel
    for (genvar c = 0; c < NCH; c++) begin : g_ch
        rwa_state_t st, next_st;
        logic [4:0] bound, next_bound, hit_idx;
        logic [19:0] raw_m, prev, word_q, next_word;
        logic [39:0] comb_w, sh_next;
        logic [19:0] hit;
        logic any_hit, slow_q, next_slow_q, slip_go;
        logic align_lvl, align_lvl_d, align_trig;
        logic pdet, next_pdet, realign, next_realign, sync_lvl, next_sync_lvl;
        logic [SYNC_DELAY-1:0] rise_pipe, next_rise_pipe; // one stage per clock of detect-to-sync delay

        assign raw_m = pma_data[c*MAXW+:MAXW] & mask;
        // earlier bits sit low: previous word then current word
        assign comb_w = ({20'h00000, raw_m} << w) | {20'h00000, prev};

        for (genvar k = 0; k < MAXW; k++) begin : g_pos
            logic [39:0] sh;
            assign sh = comb_w >> k;
            assign hit[k] = (5'(k) < w) && ((sh[19:0] & mask) == pat_m);
        end

        // lowest matching offset wins
        always_comb begin
            hit_idx = 5'h00;
            for (int k = MAXW - 1; k >= 0; k--) begin
                if (hit[k]) hit_idx = 5'(k);
            end
        end
        assign any_hit = |hit;

        // one slow sample per window, rising edge gives one slip
        assign next_slow_q = slow_en ? slip_s[c] : slow_q;
        assign slip_go = slow_en & slip_s[c] & !slow_q & slip_mode_ok;

        // pin and register bit merge into one request
        assign align_lvl = manual & ((ALIGN_PORT_EN & align_s[c]) | ctrl[CTRL_ALIGN_EN]);
        assign align_trig = (wsel == RWA_W10) ? align_lvl : (align_lvl & !align_lvl_d);

        // boundary, state and status next values
        always_comb begin
            next_st = st;
            next_bound = (bound >= w) ? BOUND_RESET : bound;
            next_realign = 1'b0;
            next_sync_lvl = sync_lvl;
            if (chan_rst[c]) begin
                next_st = RWA_IDLE;
                next_bound = BOUND_RESET;
                next_sync_lvl = 1'b0;
            end else if (!manual) begin
                next_st = RWA_IDLE;
                next_sync_lvl = 1'b0;
                if (slip_go) next_bound = (bound >= w - 5'h01) ? 5'h00 : bound + 5'h01;
            end else begin
                unique case (st)
                    RWA_IDLE: if (align_trig) next_st = RWA_SEARCH;
                    RWA_SEARCH: begin
                        next_sync_lvl = 1'b0;
                        if (any_hit) begin
                            next_st = RWA_LOCKED;
                            next_bound = hit_idx;
                            next_realign = hit_idx != bound;
                        end
                    end
                    RWA_LOCKED: begin
                        if (align_trig) begin
                            next_st = RWA_SEARCH;
                            next_sync_lvl = 1'b0;
                        end else if (rise_pipe[SYNC_DELAY-1]) begin
                            next_sync_lvl = 1'b1;
                        end
                    end
                    default: next_st = RWA_IDLE;
                endcase
            end
            sh_next = comb_w >> next_bound;
            next_word = sh_next[19:0] & mask;
            next_pdet = manual & !chan_rst[c] & hit[next_bound];
            next_rise_pipe = chan_rst[c] ? '0 : {rise_pipe[SYNC_DELAY-2:0], next_pdet & !pdet};
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                st <= RWA_IDLE;
                bound <= BOUND_RESET;
                prev <= 20'h00000;
                word_q <= 20'h00000;
                slow_q <= 1'b0;
                align_lvl_d <= 1'b0;
                pdet <= 1'b0;
                realign <= 1'b0;
                sync_lvl <= 1'b0;
                rise_pipe <= '0;
            end else begin
                st <= next_st;
                bound <= next_bound;
                prev <= raw_m;
                word_q <= next_word;
                slow_q <= next_slow_q;
                align_lvl_d <= align_lvl;
                pdet <= next_pdet;
                realign <= next_realign;
                sync_lvl <= next_sync_lvl;
                rise_pipe <= next_rise_pipe;
            end
        end

        assign pattern_detect[c] = pdet;
        assign sync_status[c] = sync_lvl | realign;
        assign bound_all[c*BOUND_BITS+:BOUND_BITS] = bound;

        // buffer toward fabric; a stalled fabric shows as pma_ready low and overflow
        rwa_fifo #(.W(MAXW), .DEPTH(FIFO_DEPTH)) u_fifo (
            .clk(pclk),
            .rst_n(presetn),
            .in_valid(1'b1),
            .in_ready(fifo_in_ready[c]),
            .in_data(word_q),
            .out_valid(rx_valid[c]),
            .out_ready(rx_ready[c]),
            .out_data(rx_data[c*MAXW+:MAXW])
        );
        assign pma_ready[c] = fifo_in_ready[c];

        slip_step_a: assert property (slip_go && !chan_rst[c] && bound < w - 5'h01 |=> bound == $past(bound) + 5'h01)
            else $error("slip did not advance boundary by one");
        slip_wrap_a: assert property (slip_go && !chan_rst[c] && bound == w - 5'h01 |=> bound == 5'h00)
            else $error("slip did not wrap at word width");
        slip_gate_a: assert property (!manual && !slip_mode_ok && !chan_rst[c] && bound < w |=> $stable(bound))
            else $error("boundary moved with slip disabled");
        pdet_match_a: assert property (manual && !chan_rst[c] && st == RWA_LOCKED && !align_trig && hit[bound]
                                       |=> pattern_detect[c])
            else $error("pattern match not reported");
        sync_delay_a: assert property (($rose(pdet) && st == RWA_LOCKED)
                                       ##1 (st == RWA_LOCKED && manual && !chan_rst[c] && !align_trig) [*2]
                                       |=> sync_lvl)
            else $error("sync status not three cycles after detect");
        realign_pulse_a: assert property (manual && !chan_rst[c] && st == RWA_SEARCH && any_hit && hit_idx != bound
                                          |=> sync_status[c] && bound == $past(hit_idx) ##1 !realign)
            else $error("realign did not pulse sync for one cycle");
        chan_reset_a: assert property (chan_rst[c] |=> bound == BOUND_RESET && !pdet && !sync_lvl)
            else $error("channel reset did not clear alignment");
        level_trig_a: assert property (wsel == RWA_W10 && align_lvl && st == RWA_LOCKED && !chan_rst[c]
                                       |=> st == RWA_SEARCH)
            else $error("level request at 10 bits not honoured");
        edge_only_a: assert property (wsel != RWA_W10 && manual && align_lvl_d && st == RWA_LOCKED && !chan_rst[c]
                                      |=> st == RWA_LOCKED)
            else $error("held request retriggered in edge mode");
        reg_trig_a: assert property (manual && !chan_rst[c] && st == RWA_IDLE && $rose(ctrl[CTRL_ALIGN_EN])
                                     |=> st == RWA_SEARCH)
            else $error("register bit did not start alignment");
        frame_a: assert property (!chan_rst[c] && slip_go |=> word_q == 20'(($past(comb_w) >> bound) & {20'h00000, mask}))
            else $error("output word not framed on new boundary");

        slip_c: cover property (slip_go ##1 $changed(bound));
        realign_c: cover property (realign);
        sync_c: cover property ($rose(sync_lvl));
        stall_c: cover property (!fifo_in_ready[c]);
    end
endmodule // rwa_aligner

// *** testbench/rwa_fabric_model.sv ***
// fabric side model: consumes aligned words with random stalls
// assumes one channel and the aligner's valid/ready handshake on pclk
`timescale 1ns/1ps
module rwa_fabric_model (
    input wire logic pclk, // parallel clock
    input wire logic presetn, // async reset, active low
    input wire logic rx_valid, // word offered
    input wire logic [19:0] rx_data, // aligned word
    output logic rx_ready // word accepted
);
    logic [31:0] st;
    // xorshift step, repeatable from a fixed start
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    // stall about one cycle in four so the fifo really backs up
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= 32'hb70d;
            rx_ready <= 1'b0;
        end else begin
            st <= xs(st);
            rx_ready <= (st[1:0] != 2'h0);
        end
    end
endmodule // rwa_fabric_model

// *** testbench/rx_word_aligner_slip_manual_tb_top.sv ***
// testbench: slip and manual alignment per width, registers over apb
// assumes one channel and the fabric model consuming rx data
`timescale 1ns/1ps
module rx_word_aligner_slip_manual_tb_top;
    import rwa_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, last_err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, seed;
    logic pma_ready, slip_request, align_request, rx_valid, rx_ready, pattern_detect, sync_status;
    logic [19:0] pma_data, rx_data, cur;
    int bad_count, checks_done, k, n;
    int wd[4] = '{8, 10, 16, 20};
    logic [19:0] pats[4] = '{20'h00017, 20'h0017c, 20'h01a2b, 20'h1a2b3};

    rwa_aligner #(.NCH(1), .FIFO_DEPTH(8), .SLIP_PORT_EN(1'b1), .ALIGN_PORT_EN(1'b1)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pma_data(pma_data), .pma_ready(pma_ready), .slip_request(slip_request),
        .align_request(align_request), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
        .pattern_detect(pattern_detect), .sync_status(sync_status));
    rwa_fabric_model model_u (.pclk(pclk), .presetn(presetn), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_ready(rx_ready));

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // word seen at boundary b of a constant stream of word x, w bits wide
    function automatic logic [19:0] rotr(input logic [19:0] x, input int b, input int w);
        logic [39:0] t;
        t = ({20'h0, x} | ({20'h0, x} << w)) >> b;
        return t[19:0] & ((20'h1 << w) - 20'h1);
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // one apb transfer; held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // hold channel reset; boundary reads back as default and both status outputs clear
    task automatic chrst();
        apb(1'b1, REG_CHRST, 32'h1, rd);
        apb(1'b0, REG_BOUND, 32'h0, rd);
        chk(rd & 32'h1f, 32'h0);
        chk({30'h0, sync_status, pattern_detect}, 32'h0);
        apb(1'b1, REG_CHRST, 32'h0, rd);
    endtask
    // one slip request, high and low long enough for the slow sampler
    task automatic slip();
        slip_request <= 1'b1;
        repeat (25) @(posedge pclk);
        slip_request <= 1'b0;
        repeat (25) @(posedge pclk);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // watchdog well beyond the expected run of about 4k cycles
    initial begin
        #600000;
        bad_count++;
        finish_test();
    end
    always @(posedge pclk) pma_data <= cur;

    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, slip_request, align_request} = 5'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        cur = 20'h0;
        seed = 32'hb70d;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, REG_CTRL, 32'h0, rd);
        chk(rd, CTRL_RESET);
        apb(1'b0, 8'h40, 32'h0, rd);
        chk({31'h0, last_err}, 32'h1);
        for (int s = 0; s < 4; s++) begin
            cur = pats[s];
            // slip feature off: the pin must not move the boundary
            apb(1'b1, REG_CTRL, s << 2, rd);
            chrst();
            slip();
            apb(1'b0, REG_BOUND, 32'h0, rd);
            chk(rd & 32'h1f, 32'h0);
            apb(1'b1, REG_CTRL, (s << 2) | 2, rd);
            // as many slips as the width so the wrap to zero is seen
            for (int i = 1; i <= wd[s]; i++) begin
                slip();
                apb(1'b0, REG_BOUND, 32'h0, rd);
                chk(rd & 32'h1f, i % wd[s]);
                chk({12'h0, rx_data}, {12'h0, rotr(cur, i % wd[s], wd[s])});
            end
            // manual mode: stream holds the pattern at a random offset
            k = 1 + (xs() % (wd[s] - 1));
            cur = rotr(pats[s], wd[s] - k, wd[s]);
            apb(1'b1, REG_PATTERN, {12'h0, pats[s]}, rd);
            apb(1'b1, REG_CTRL, (s << 2) | 1, rd);
            chrst();
            if (s % 2 == 0) begin
                align_request <= 1'b1;
                repeat (4) @(posedge pclk);
                align_request <= 1'b0;
            end else begin
                apb(1'b1, REG_CTRL, (s << 2) | 17, rd);
                apb(1'b1, REG_CTRL, (s << 2) | 1, rd);
            end
            n = 0;
            while (pattern_detect !== 1'b1 && n < 200) begin
                @(posedge pclk);
                n++;
            end
            chk({31'h0, pattern_detect}, 32'h1);
            chk({31'h0, sync_status}, 32'h1);
            @(posedge pclk);
            chk({31'h0, sync_status}, 32'h0);
            @(posedge pclk);
            chk({31'h0, sync_status}, 32'h0);
            @(posedge pclk);
            chk({31'h0, sync_status}, 32'h1);
            apb(1'b0, REG_BOUND, 32'h0, rd);
            chk(rd & 32'h1f, k);
            repeat (40) @(posedge pclk);
            chk({31'h0, pattern_detect}, 32'h1);
            chk({12'h0, rx_data}, {12'h0, pats[s]});
            // fabric is slower than the stream, so overflow is set by now
            apb(1'b0, REG_STATUS, 32'h0, rd);
            chk(rd, (32'h1 << STAT_SYNC_LO) | (32'h1 << STAT_PDET_LO) | (32'h1 << STAT_OVF_LO));
            // channel reset while locked off boundary zero
            chrst();
        end
        finish_test();
    end
endmodule // rx_word_aligner_slip_manual_tb_top
